// ---- eif_pkg.sv ----
// Constants shared by the external interrupt filter and edge block
// Operation
// - Six external inputs, each noise filtered before edge detection.
// - Input 0 pin defaults to port function after reset.
// - Inputs 0 and 5 falling edge only; reject under 2/fc, accept 7/fc.
// - Input 1 rejects under 15/fc or 63/fc; accepts 49/fc or 193/fc.
// - Inputs 2,3,4 reject under 7/fc, accept 25/fc or longer.
// - Slow or sleep: reject under 1/fs, accept 3.5/fs, low clock timed.
// - Control bit 7: 0 selects 63/fc, 1 selects 15/fc for input 1.
// - Input 1 noise width change takes effect within 2^6 fast clocks.
// - Input 4 select: 00 rise, 01 fall, 10 both, 11 high level.
// - Clean edge sets latch within establishment time plus 6/fs.
// - Input 0 latch not set while pin function select is 0.
// - Requests need master and own enable; 0 pin select; 4,5 route zero.
// - Spurious edges from pin output changes are not suppressed.
// - Input 4 high level after reset needs a rising edge first.
`default_nettype none
package eif_pkg;
	localparam int NUM_IN = 6;
	localparam logic [7:0] ADDR_CTRL = 8'h37;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int BIT_NC = 7;
	localparam int BIT_IN0EN = 6;
	localparam int BIT_IN4ES_HI = 5;
	localparam int BIT_IN4ES_LO = 4;
	localparam int BIT_IN3ES = 3;
	localparam int BIT_IN2ES = 2;
	localparam int BIT_IN1ES = 1;
	// Filter acceptance thresholds in clock periods of the filter clock
	localparam logic [7:0] ACC_SHORT = 8'h07;
	localparam logic [7:0] ACC_MID = 8'h19;
	localparam logic [7:0] ACC_IN1_NC1 = 8'h31;
	localparam logic [7:0] ACC_IN1_NC0 = 8'hC1;
	localparam logic [7:0] ACC_SLOW = 8'h03;
	localparam int NC_SETTLE_CYC = 64;
	localparam logic [1:0] ES_RISE = 2'h0;
	localparam logic [1:0] ES_FALL = 2'h1;
	localparam logic [1:0] ES_BOTH = 2'h2;
	localparam logic [1:0] ES_HIGH = 2'h3;
endpackage
`default_nettype wire

// ---- eif_filter.sv ----
// One noise filter channel: two-stage synchroniser and run-length filter
`default_nettype none
module eif_filter (
	input wire logic ref_clk, // System clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic tick, // Filter clock enable
	input wire logic pinIn, // Raw pin
	input wire logic [7:0] accCount, // Stable ticks needed to accept
	output logic filtOut // Filtered level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic lvl;
		logic [7:0] cnt;
	} eif_filt_state_t;
	eif_filt_state_t st_q, st_d;
	always_comb begin
		st_d = st_q;
		st_d.s1 = pinIn;
		st_d.s2 = st_q.s1;
		if (tick) begin
			// Shorter disagreement restarts the count, so short pulses vanish
			if (st_q.s2 == st_q.lvl) begin
				st_d.cnt = 8'h00;
			end else if (st_q.cnt + 8'h01 >= accCount) begin
				st_d.lvl = st_q.s2;
				st_d.cnt = 8'h00;
			end else begin
				st_d.cnt = st_q.cnt + 8'h01;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			// Follow the pin during reset, so a level held across reset is not seen as an edge
			st_q.s1 <= pinIn;
			st_q.s2 <= pinIn;
			st_q.lvl <= pinIn;
			st_q.cnt <= 8'h00;
		end else begin
			st_q <= st_d;
		end
	end
	assign filtOut = st_q.lvl;
endmodule
`default_nettype wire

// ---- eif_top.sv ----
// External interrupt filter, edge detector and latch block
//
// Chosen here: strobed register access.
`default_nettype none
module eif_top (
	input wire logic ref_clk, // 250 MHz clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic [5:0] extIrqIn, // Interrupt pins 0..5
	input wire logic slowMode, // Slow or sleep clock mode
	input wire logic lowClkTick, // Low clock enable pulse
	input wire logic masterIrqEnable, // Master enable
	input wire logic [5:0] irqEnableFlag, // Individual enables
	input wire logic latchRouteSelIn4, // Route bit input 4
	input wire logic latchRouteSelIn5, // Route bit input 5
	input wire logic [5:0] latchClr, // Latch clear pulses
	input wire logic [7:0] regAddr, // Register address
	input wire logic [7:0] regWdata, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	output logic [7:0] regRdata, // Read data
	output logic [5:0] irqLatch, // Interrupt latches
	output logic [5:0] irqRequest, // Enabled requests
	output logic in0PinFuncSel // Shared pin as interrupt
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] rdata;
		logic [5:0] prev;
		logic [5:0] lat;
		logic armed4;
		logic [6:0] settle;
		logic ncEff;
	} eif_state_t;
	eif_state_t st_q, st_d;
	logic [5:0] filt;
	logic [7:0] acc [6];
	logic tick;
	function automatic logic edgeHit(input logic [1:0] sel, input logic p, input logic c);
		case (sel)
			eif_pkg::ES_RISE: edgeHit = ~p & c;
			eif_pkg::ES_FALL: edgeHit = p & ~c;
			eif_pkg::ES_BOTH: edgeHit = p ^ c;
			default: edgeHit = c;
		endcase
	endfunction
	// ************************************************
	// Filter clock and thresholds
	// ************************************************
	assign tick = slowMode ? lowClkTick : 1'b1;
	always_comb begin
		for (int i = 0; i < eif_pkg::NUM_IN; i++) begin
			acc[i] = eif_pkg::ACC_MID;
		end
		acc[0] = eif_pkg::ACC_SHORT;
		acc[5] = eif_pkg::ACC_SHORT;
		acc[1] = st_q.ncEff ? eif_pkg::ACC_IN1_NC1 : eif_pkg::ACC_IN1_NC0;
		if (slowMode) begin
			for (int i = 0; i < eif_pkg::NUM_IN; i++) begin
				acc[i] = eif_pkg::ACC_SLOW;
			end
		end
	end
	for (genvar g = 0; g < eif_pkg::NUM_IN; g++) begin : g_filt
		eif_filter u_filt (
			.ref_clk(ref_clk),
			.sys_rst(sys_rst),
			.tick(tick),
			.pinIn(extIrqIn[g]),
			.accCount(acc[g]),
			.filtOut(filt[g])
		);
	end
	// ************************************************
	// Registers, edges and latches
	// ************************************************
	always_comb begin
		logic [5:0] hit;
		logic [1:0] s4;
		st_d = st_q;
		hit = '0;
		s4 = st_q.ctrl[eif_pkg::BIT_IN4ES_HI:eif_pkg::BIT_IN4ES_LO];
		st_d.rdata = '0;
		if (regWr && regAddr == eif_pkg::ADDR_CTRL) begin
			st_d.ctrl = regWdata;
		end
		if (regRd && regAddr == eif_pkg::ADDR_CTRL) begin
			st_d.rdata = st_q.ctrl;
		end
		// Noise width switch waits a bounded settle time before the new threshold applies
		if (st_q.ncEff != st_q.ctrl[eif_pkg::BIT_NC]) begin
			st_d.settle = st_q.settle + 7'h01;
			if (st_q.settle == 7'(eif_pkg::NC_SETTLE_CYC - 2)) begin
				st_d.ncEff = st_q.ctrl[eif_pkg::BIT_NC];
				st_d.settle = '0;
			end
		end else begin
			st_d.settle = '0;
		end
		st_d.prev = filt;
		// Edges from pin output changes are passed on unchanged
		hit[0] = st_q.prev[0] & ~filt[0] & st_q.ctrl[eif_pkg::BIT_IN0EN];
		hit[5] = st_q.prev[5] & ~filt[5];
		hit[1] = edgeHit({1'b0, st_q.ctrl[eif_pkg::BIT_IN1ES]}, st_q.prev[1], filt[1]);
		hit[2] = edgeHit({1'b0, st_q.ctrl[eif_pkg::BIT_IN2ES]}, st_q.prev[2], filt[2]);
		hit[3] = edgeHit({1'b0, st_q.ctrl[eif_pkg::BIT_IN3ES]}, st_q.prev[3], filt[3]);
		if (~st_q.prev[4] & filt[4]) begin
			st_d.armed4 = 1'b1;
		end
		hit[4] = edgeHit(s4, st_q.prev[4], filt[4]);
		if (s4 == eif_pkg::ES_HIGH) begin
			hit[4] = filt[4] & (st_q.armed4 | ~st_q.prev[4]);
		end
		// Set wins over clear; latch is set one cycle after the filtered edge
		st_d.lat = (st_q.lat & ~latchClr) | hit;
	end
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= '0;
			st_q.ctrl <= eif_pkg::CTRL_RESET;
			st_q.prev <= filt;
		end else begin
			st_q <= st_d;
		end
	end
	assign regRdata = st_q.rdata;
	assign irqLatch = st_q.lat;
	assign in0PinFuncSel = st_q.ctrl[eif_pkg::BIT_IN0EN];
	always_comb begin
		irqRequest = st_q.lat & irqEnableFlag & {6{masterIrqEnable}};
		irqRequest[0] = irqRequest[0] & st_q.ctrl[eif_pkg::BIT_IN0EN];
		irqRequest[4] = irqRequest[4] & ~latchRouteSelIn4;
		irqRequest[5] = irqRequest[5] & ~latchRouteSelIn5;
	end
	// ************************************************
	// Checks
	// ************************************************
	property p_in0_port;
		@(posedge ref_clk) disable iff (sys_rst)
			!st_q.ctrl[eif_pkg::BIT_IN0EN] && !latchClr[0] |=> $stable(st_q.lat[0]) || !st_q.lat[0];
	endproperty
	a_in0_port: assert property (p_in0_port) else $error("input 0 latched in port mode");
	property p_rst_ctrl;
		@(posedge ref_clk) sys_rst |=> st_q.ctrl == eif_pkg::CTRL_RESET;
	endproperty
	a_rst_ctrl: assert property (p_rst_ctrl) else $error("control not reset");
	property p_req;
		@(posedge ref_clk) disable iff (sys_rst)
			irqRequest[0] |-> masterIrqEnable && irqEnableFlag[0] && in0PinFuncSel;
	endproperty
	a_req: assert property (p_req) else $error("request without enables");
	property p_req5;
		@(posedge ref_clk) disable iff (sys_rst) latchRouteSelIn5 |-> !irqRequest[5];
	endproperty
	a_req5: assert property (p_req5) else $error("routed input 5 requested");
	property p_nc;
		@(posedge ref_clk) disable iff (sys_rst)
			$changed(st_q.ctrl[eif_pkg::BIT_NC]) |-> ##[0:64] st_q.ncEff == st_q.ctrl[eif_pkg::BIT_NC];
	endproperty
	a_nc: assert property (p_nc) else $error("noise select slow");
	property p_fall5;
		@(posedge ref_clk) disable iff (sys_rst) st_q.prev[5] && !filt[5] |=> st_q.lat[5];
	endproperty
	a_fall5: assert property (p_fall5) else $error("input 5 edge lost");
	property p_rise1;
		@(posedge ref_clk) disable iff (sys_rst)
			!st_q.ctrl[eif_pkg::BIT_IN1ES] && !st_q.prev[1] && filt[1] |=> st_q.lat[1];
	endproperty
	a_rise1: assert property (p_rise1) else $error("input 1 rise lost");
	property p_filt_fast;
		@(posedge ref_clk) disable iff (sys_rst)
			!slowMode && $rose(filt[2]) |-> $past(extIrqIn[2], 3);
	endproperty
	a_filt_fast: assert property (p_filt_fast) else $error("filter passed glitch");
	// ************************************************
	// Register port and noise select settle checks
	// ************************************************
	property p_wr_ctrl;
		@(posedge ref_clk) disable iff (sys_rst)
			regWr && regAddr == eif_pkg::ADDR_CTRL |=> st_q.ctrl == $past(regWdata);
	endproperty
	a_wr_ctrl: assert property (p_wr_ctrl) else $error("control write lost");
	property p_rd_ctrl;
		@(posedge ref_clk) disable iff (sys_rst)
			regRd && regAddr == eif_pkg::ADDR_CTRL |=> regRdata == $past(st_q.ctrl);
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");
	property p_rd_idle;
		@(posedge ref_clk) disable iff (sys_rst)
			!(regRd && regAddr == eif_pkg::ADDR_CTRL) |=> regRdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
	property p_nc_step;
		@(posedge ref_clk) disable iff (sys_rst)
			$changed(st_q.ncEff) |-> $past(st_q.settle) == 7'(eif_pkg::NC_SETTLE_CYC - 2);
	endproperty
	a_nc_step: assert property (p_nc_step) else $error("noise select switched early");
	property p_nc_bound;
		@(posedge ref_clk) disable iff (sys_rst)
			st_q.settle < 7'(eif_pkg::NC_SETTLE_CYC - 1);
	endproperty
	a_nc_bound: assert property (p_nc_bound) else $error("settle count overrun");
	// ************************************************
	// Filter checks
	// ************************************************
	// In slow mode the level may only move on a low clock tick
	property p_slow_hold;
		@(posedge ref_clk) disable iff (sys_rst)
			slowMode && !lowClkTick |=> $stable(filt);
	endproperty
	a_slow_hold: assert property (p_slow_hold) else $error("filter moved without tick");
	property p_filt0_fast;
		@(posedge ref_clk) disable iff (sys_rst)
			!slowMode && !$past(slowMode, 9) && $rose(filt[0]) |-> $past(extIrqIn[0], 3) && $past(extIrqIn[0], 9);
	endproperty
	a_filt0_fast: assert property (p_filt0_fast) else $error("input 0 short pulse passed");
	property p_filt5_fast;
		@(posedge ref_clk) disable iff (sys_rst)
			!slowMode && !$past(slowMode, 9) && $fell(filt[5]) |-> !$past(extIrqIn[5], 3) && !$past(extIrqIn[5], 9);
	endproperty
	a_filt5_fast: assert property (p_filt5_fast) else $error("input 5 short pulse passed");
	property p_filt1_nc1;
		@(posedge ref_clk) disable iff (sys_rst)
			!slowMode && !$past(slowMode, 51) && st_q.ncEff && $past(st_q.ncEff, 51) && $fell(filt[1]) |->
			!$past(extIrqIn[1], 3) && !$past(extIrqIn[1], 51);
	endproperty
	a_filt1_nc1: assert property (p_filt1_nc1) else $error("input 1 short pulse passed");
	// ************************************************
	// Edge and latch checks
	// ************************************************
	property p_rose0;
		@(posedge ref_clk) disable iff (sys_rst)
			$rose(st_q.lat[0]) |-> $past(st_q.ctrl[eif_pkg::BIT_IN0EN]);
	endproperty
	a_rose0: assert property (p_rose0) else $error("input 0 set in port mode");
	property p_fall0;
		@(posedge ref_clk) disable iff (sys_rst)
			st_q.ctrl[eif_pkg::BIT_IN0EN] && st_q.prev[0] && !filt[0] |=> st_q.lat[0];
	endproperty
	a_fall0: assert property (p_fall0) else $error("input 0 edge lost");
	property p_rose5;
		@(posedge ref_clk) disable iff (sys_rst)
			$rose(st_q.lat[5]) |-> $past(st_q.prev[5]) && !$past(filt[5]);
	endproperty
	a_rose5: assert property (p_rose5) else $error("input 5 set without falling edge");
	property p_fall3;
		@(posedge ref_clk) disable iff (sys_rst)
			st_q.ctrl[eif_pkg::BIT_IN3ES] && st_q.prev[3] && !filt[3] |=> st_q.lat[3];
	endproperty
	a_fall3: assert property (p_fall3) else $error("input 3 fall lost");
	property p_rise2;
		@(posedge ref_clk) disable iff (sys_rst)
			!st_q.ctrl[eif_pkg::BIT_IN2ES] && !st_q.prev[2] && filt[2] |=> st_q.lat[2];
	endproperty
	a_rise2: assert property (p_rise2) else $error("input 2 rise lost");
	property p_both4;
		@(posedge ref_clk) disable iff (sys_rst)
			st_q.ctrl[eif_pkg::BIT_IN4ES_HI:eif_pkg::BIT_IN4ES_LO] == eif_pkg::ES_BOTH && st_q.prev[4] != filt[4]
			|=> st_q.lat[4];
	endproperty
	a_both4: assert property (p_both4) else $error("input 4 edge lost");
	property p_fall4;
		@(posedge ref_clk) disable iff (sys_rst)
			st_q.ctrl[eif_pkg::BIT_IN4ES_HI:eif_pkg::BIT_IN4ES_LO] == eif_pkg::ES_FALL && st_q.prev[4] && !filt[4]
			|=> st_q.lat[4];
	endproperty
	a_fall4: assert property (p_fall4) else $error("input 4 fall lost");
	property p_high4;
		@(posedge ref_clk) disable iff (sys_rst)
			st_q.ctrl[eif_pkg::BIT_IN4ES_HI:eif_pkg::BIT_IN4ES_LO] == eif_pkg::ES_HIGH && st_q.armed4 && filt[4]
			|=> st_q.lat[4];
	endproperty
	a_high4: assert property (p_high4) else $error("input 4 high level lost");
	// A pin that stays high and has never risen since reset must stay silent
	property p_arm4;
		@(posedge ref_clk) disable iff (sys_rst)
			!st_q.armed4 && st_q.prev[4] && filt[4] && !st_q.lat[4] |=> !st_q.lat[4];
	endproperty
	a_arm4: assert property (p_arm4) else $error("input 4 set without rising edge");
	property p_arm_keep;
		@(posedge ref_clk) disable iff (sys_rst)
			st_q.armed4 |=> st_q.armed4;
	endproperty
	a_arm_keep: assert property (p_arm_keep) else $error("input 4 arm lost");
	property p_clr2;
		@(posedge ref_clk) disable iff (sys_rst)
			latchClr[2] && st_q.prev[2] == filt[2] |=> !st_q.lat[2];
	endproperty
	a_clr2: assert property (p_clr2) else $error("input 2 latch not cleared");
	// ************************************************
	// Request gating checks
	// ************************************************
	property p_req4;
		@(posedge ref_clk) disable iff (sys_rst)
			latchRouteSelIn4 |-> !irqRequest[4];
	endproperty
	a_req4: assert property (p_req4) else $error("routed input 4 requested");
	property p_req_master;
		@(posedge ref_clk) disable iff (sys_rst)
			!masterIrqEnable |-> irqRequest == 6'h00;
	endproperty
	a_req_master: assert property (p_req_master) else $error("request with master off");
	property p_req_flag;
		@(posedge ref_clk) disable iff (sys_rst)
			(irqRequest & ~irqEnableFlag) == 6'h00;
	endproperty
	a_req_flag: assert property (p_req_flag) else $error("request with flag off");
	property p_req_lat;
		@(posedge ref_clk) disable iff (sys_rst)
			(irqRequest & ~st_q.lat) == 6'h00;
	endproperty
	a_req_lat: assert property (p_req_lat) else $error("request without latch");
	property p_req_full;
		@(posedge ref_clk) disable iff (sys_rst)
			masterIrqEnable && irqEnableFlag[2] && st_q.lat[2] |-> irqRequest[2];
	endproperty
	a_req_full: assert property (p_req_full) else $error("enabled request missing");
	c_in0: cover property (@(posedge ref_clk) irqRequest[0]);
	c_in4: cover property (@(posedge ref_clk) st_q.lat[4] && s4_high());
	c_nc: cover property (@(posedge ref_clk) $rose(st_q.ncEff));
	c_in5: cover property (@(posedge ref_clk) irqRequest[5]);
	c_slow: cover property (@(posedge ref_clk) slowMode && $rose(st_q.lat[2]));
	function automatic logic s4_high();
		s4_high = st_q.ctrl[eif_pkg::BIT_IN4ES_HI:eif_pkg::BIT_IN4ES_LO] == eif_pkg::ES_HIGH;
	endfunction
endmodule
`default_nettype wire

// ---- eif_pin_src.sv ----
// Model of the sources that drive the six interrupt pins
`default_nettype none
module eif_pin_src (
	input wire logic ref_clk, // Clock
	output logic [5:0] pins // Pin levels
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-ups hold idle pins high; pin 0 is only ever an input here
	initial pins = 6'h3F;
	task automatic pulse(input int ch, input int w);
		@(posedge ref_clk);
		pins[ch] <= 1'b0;
		repeat (w) @(posedge ref_clk);
		pins[ch] <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the external interrupt filter block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] ctrl; int ch; int w; logic exp;} eif_row_t;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic slowMode = 1'b0;
	logic lowClkTick = 1'b0;
	logic masterIrqEnable = 1'b1;
	logic [5:0] irqEnableFlag = 6'h3F;
	logic routeIn4 = 1'b0;
	logic routeIn5 = 1'b0;
	logic [5:0] latchClr = 6'h00;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdata;
	logic [5:0] irqLatch, irqRequest, pins;
	logic in0PinFuncSel;
	int error_cnt = 0;
	int check_count = 0;
	int tickCnt = 0;
	eif_row_t rows[19] = '{'{8'h40, 0, 1, 1'b0}, '{8'h40, 0, 300, 1'b1}, '{8'h00, 0, 300, 1'b0},
		'{8'h00, 5, 1, 1'b0}, '{8'h00, 5, 300, 1'b1}, '{8'h04, 2, 5, 1'b0}, '{8'h00, 2, 300, 1'b0},
		'{8'h04, 2, 300, 1'b1}, '{8'h08, 3, 300, 1'b1}, '{8'h00, 3, 300, 1'b0}, '{8'h00, 1, 300, 1'b0},
		'{8'h02, 1, 300, 1'b1}, '{8'h02, 1, 60, 1'b0}, '{8'h82, 1, 10, 1'b0}, '{8'h82, 1, 60, 1'b1},
		'{8'h10, 4, 300, 1'b1}, '{8'h00, 4, 300, 1'b0}, '{8'h20, 4, 300, 1'b1}, '{8'h30, 4, 40, 1'b1}};
	eif_top i_eif_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .extIrqIn(pins), .slowMode(slowMode),
		.lowClkTick(lowClkTick), .masterIrqEnable(masterIrqEnable), .irqEnableFlag(irqEnableFlag),
		.latchRouteSelIn4(routeIn4), .latchRouteSelIn5(routeIn5), .latchClr(latchClr), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irqLatch(irqLatch),
		.irqRequest(irqRequest), .in0PinFuncSel(in0PinFuncSel));
	eif_pin_src i_eif_pin_src (.ref_clk(ref_clk), .pins(pins));
	always #2 ref_clk = ~ref_clk;
	// Low clock is one tick in eight fast cycles, always running
	always @(posedge ref_clk) begin
		tickCnt <= tickCnt + 1;
		lowClkTick <= (tickCnt % 8 == 7);
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 chk("regRdata", regRdata, exp);
	endtask
	task automatic run_row(input eif_row_t r);
		wr(8'h37, r.ctrl);
		repeat (70) @(posedge ref_clk);
		latchClr <= 6'h3F;
		@(posedge ref_clk);
		latchClr <= 6'h00;
		fork
			i_eif_pin_src.pulse(r.ch, r.w);
			begin
				repeat (250) @(posedge ref_clk);
				#1 chk("irqLatch", {7'h00, irqLatch[r.ch]}, {7'h00, r.exp});
				chk("irqRequest", {7'h00, irqRequest[r.ch]}, {7'h00, r.exp});
			end
		join
		repeat (300) @(posedge ref_clk);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(8'h37, 8'h00);
		chk("in0PinFuncSel", {7'h00, in0PinFuncSel}, 8'h00);
		wr(8'h37, 8'h30);
		repeat (300) @(posedge ref_clk);
		chk("irqLatch4", {7'h00, irqLatch[4]}, 8'h00);
		chk("irqLatch", {2'h0, irqLatch}, 8'h00);
		$display("reset test done");
		foreach (rows[i]) begin
			run_row(rows[i]);
			$display("row %0d done", i);
		end
		fork
			begin
				// Input 5 starts after the row has cleared all latches
				repeat (80) @(posedge ref_clk);
				i_eif_pin_src.pulse(5, 300);
			end
			run_row('{8'h10, 4, 300, 1'b1});
		join
		#1 chk("irqRequest", {2'h0, irqRequest}, 8'h30);
		@(posedge ref_clk);
		routeIn4 <= 1'b1;
		routeIn5 <= 1'b1;
		#1 chk("irqRequest", {2'h0, irqRequest}, 8'h00);
		@(posedge ref_clk);
		routeIn4 <= 1'b0;
		routeIn5 <= 1'b0;
		masterIrqEnable <= 1'b0;
		#1 chk("irqRequest", {2'h0, irqRequest}, 8'h00);
		@(posedge ref_clk);
		masterIrqEnable <= 1'b1;
		irqEnableFlag <= 6'h0F;
		#1 chk("irqRequest", {2'h0, irqRequest}, 8'h00);
		@(posedge ref_clk);
		irqEnableFlag <= 6'h3F;
		#1 chk("irqRequest", {2'h0, irqRequest}, 8'h30);
		@(posedge ref_clk);
		$display("gating test done");
		slowMode <= 1'b1;
		run_row('{8'h04, 2, 4, 1'b0});
		run_row('{8'h04, 2, 300, 1'b1});
		slowMode <= 1'b0;
		$display("slow test done");
		wr(8'h37, 8'hC1);
		rd(8'h37, 8'hC1);
		chk("in0PinFuncSel", {7'h00, in0PinFuncSel}, 8'h01);
		rd(8'h36, 8'h00);
		$display("register test done");
		give_verdict();
	end
	initial begin
		#200000;
		error_cnt++;
		give_verdict();
	end
endmodule
`default_nettype wire
